// >>> rtl/hbb_host_byte_buffer.sv
// host byte buffer port: master-side pins, status byte, command gate, controller stream
module hbb_host_byte_buffer
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       bus_din,
    input  wire logic             bus_a0,
    input  wire logic             bus_cs_n,
    input  wire logic             bus_rd_n,
    input  wire logic             bus_wr_n,
    output logic      [7:0]       bus_dout_q,
    output logic                  bus_doe_q,
    output hbb_pkg::hbb_word_t    out_word_q,
    output logic                  out_valid_q,
    input  wire logic             out_ready,
    input  wire hbb_pkg::hbb_word_t resp_word,
    input  wire logic             resp_valid,
    output logic                  resp_ready_q,
    input  wire logic             ctl_done,
    output logic                  busy_lock_flag_q,
    output logic                  irq_q,
    output logic                  illegal_cmd_q
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 4'hf;
            pin_s2_q <= 4'hf;
            din_s1_q <= hbb_pkg::BYTE_RST;
            din_s2_q <= hbb_pkg::BYTE_RST;
        end
        else
        begin
            pin_s1_q <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_a0};
            pin_s2_q <= pin_s1_q;
            din_s1_q <= bus_din;
            din_s2_q <= din_s1_q;
        end
    end

    logic wr_act;
    logic rd_act;
    assign wr_act = !pin_s2_q[3] && !pin_s2_q[1];
    assign rd_act = !pin_s2_q[3] && !pin_s2_q[2];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic               wr_pend_q, wr_pend_d, wr_a0_q, wr_a0_d;
    logic [7:0]         wr_data_q, wr_data_d;
    logic               rd_pend_q, rd_pend_d, rd_a0_q, rd_a0_d;
    logic               obf_q, obf_d, ibf_q, ibf_d, cd_q, cd_d, in_cd_q, in_cd_d;
    logic               busy_d, cur_irq_q, cur_irq_d;
    logic [7:0]         ibuf_q, ibuf_d, obuf_q, obuf_d;
    hbb_pkg::hbb_word_t b0_q, b0_d, b1_q, b1_d;
    logic [1:0]         cnt_q, cnt_d;
    logic               out_valid_d, resp_ready_d, irq_d, illegal_d, doe_d;
    logic [7:0]         dout_d;
    logic               wr_done, rd_done, push, pop, resp_acc, cmd_rsv;

    assign wr_done  = wr_pend_q && !wr_act;
    assign rd_done  = rd_pend_q && !rd_act;
    assign push     = ibf_q && (cnt_q != hbb_pkg::BUF_DEPTH);
    assign pop      = out_valid_q && out_ready;
    assign resp_acc = resp_valid && resp_ready_q;
    assign cmd_rsv  = hbb_pkg::hbb_is_reserved(wr_data_q[hbb_pkg::CMD_CODE_LSB +: 5]);

    always_comb
    begin
        logic [1:0]         n;
        logic [7:0]         st;
        hbb_pkg::hbb_word_t w;
        n            = cnt_q;
        st           = 8'h00;
        w            = '{cd: in_cd_q, val: ibuf_q};
        wr_pend_d    = wr_pend_q;
        wr_a0_d      = wr_a0_q;
        wr_data_d    = wr_data_q;
        rd_pend_d    = rd_pend_q;
        rd_a0_d      = rd_a0_q;
        obf_d        = obf_q;
        ibf_d        = ibf_q;
        cd_d         = cd_q;
        in_cd_d      = in_cd_q;
        busy_d       = busy_lock_flag_q;
        cur_irq_d    = cur_irq_q;
        ibuf_d       = ibuf_q;
        obuf_d       = obuf_q;
        b0_d         = b0_q;
        b1_d         = b1_q;
        irq_d        = 1'b0;
        illegal_d    = 1'b0;
        // master strobes: latch during the strobe, commit at its end
        if (wr_act)
        begin
            wr_pend_d = 1'b1;
            wr_a0_d   = pin_s2_q[0];
            wr_data_d = din_s2_q;
        end
        else if (wr_done)
        begin
            wr_pend_d = 1'b0;
        end
        if (rd_act)
        begin
            rd_pend_d = 1'b1;
            rd_a0_d   = pin_s2_q[0];
        end
        else if (rd_done)
        begin
            rd_pend_d = 1'b0;
        end
        // hand the held input byte to the controller stream
        if (pop)
        begin
            b0_d = b1_q;
            n    = n - 2'h1;
        end
        if (push)
        begin
            if (n == 2'h0)
                b0_d = w;
            else
                b1_d = w;
            n     = n + 2'h1;
            ibf_d = 1'b0;
        end
        cnt_d       = n;
        out_valid_d = (n != 2'h0);
        // master write into the input buffer; a full buffer ignores it
        if (wr_done && !ibf_q)
        begin
            if (wr_a0_q)
            begin
                if (!busy_lock_flag_q)
                begin
                    if (cmd_rsv)
                    begin
                        illegal_d = 1'b1;
                    end
                    else
                    begin
                        // code and control field travel with the byte
                        ibuf_d    = wr_data_q;
                        ibf_d     = 1'b1;
                        in_cd_d   = 1'b1;
                        cd_d      = 1'b1;
                        busy_d    = 1'b1;
                        cur_irq_d = wr_data_q[hbb_pkg::CMD_IRQ_BIT] &&
                                    wr_data_q[hbb_pkg::CMD_DEV_BIT];
                    end
                end
            end
            else
            begin
                ibuf_d  = wr_data_q;
                ibf_d   = 1'b1;
                in_cd_d = 1'b0;
                cd_d    = 1'b0;
            end
        end
        // controller answer into the output buffer
        if (resp_acc)
        begin
            obuf_d = resp_word.val;
            obf_d  = 1'b1;
            cd_d   = resp_word.cd;
        end
        else if (rd_done && !rd_a0_q)
        begin
            obf_d = 1'b0;
        end
        if (ctl_done && busy_lock_flag_q)
        begin
            busy_d = 1'b0;
            irq_d  = cur_irq_q;
        end
        resp_ready_d = busy_d && !obf_d;
        // read drive: data port returns the output byte, control port the status
        st[hbb_pkg::ST_OUT_FULL_BIT] = obf_q;
        st[hbb_pkg::ST_IN_FULL_BIT]  = ibf_q;
        st[hbb_pkg::ST_BUSY_BIT]     = busy_lock_flag_q;
        st[hbb_pkg::ST_CD_BIT]       = cd_q;
        doe_d  = rd_act;
        dout_d = pin_s2_q[0] ? st : obuf_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q        <= hbb_pkg::FLAG_RST;
            wr_a0_q          <= hbb_pkg::FLAG_RST;
            wr_data_q        <= hbb_pkg::BYTE_RST;
            rd_pend_q        <= hbb_pkg::FLAG_RST;
            rd_a0_q          <= hbb_pkg::FLAG_RST;
            obf_q            <= hbb_pkg::FLAG_RST;
            ibf_q            <= hbb_pkg::FLAG_RST;
            busy_lock_flag_q <= hbb_pkg::FLAG_RST;
            cd_q             <= hbb_pkg::FLAG_RST;
            in_cd_q          <= hbb_pkg::FLAG_RST;
            cur_irq_q        <= hbb_pkg::FLAG_RST;
            ibuf_q           <= hbb_pkg::BYTE_RST;
            obuf_q           <= hbb_pkg::BYTE_RST;
            b0_q             <= '0;
            b1_q             <= '0;
            cnt_q            <= 2'h0;
            out_word_q       <= '0;
            out_valid_q      <= hbb_pkg::FLAG_RST;
            resp_ready_q     <= hbb_pkg::FLAG_RST;
            irq_q            <= hbb_pkg::FLAG_RST;
            illegal_cmd_q    <= hbb_pkg::FLAG_RST;
            bus_doe_q        <= hbb_pkg::FLAG_RST;
            bus_dout_q       <= hbb_pkg::BYTE_RST;
        end
        else
        begin
            wr_pend_q        <= wr_pend_d;
            wr_a0_q          <= wr_a0_d;
            wr_data_q        <= wr_data_d;
            rd_pend_q        <= rd_pend_d;
            rd_a0_q          <= rd_a0_d;
            obf_q            <= obf_d;
            ibf_q            <= ibf_d;
            busy_lock_flag_q <= busy_d;
            cd_q             <= cd_d;
            in_cd_q          <= in_cd_d;
            cur_irq_q        <= cur_irq_d;
            ibuf_q           <= ibuf_d;
            obuf_q           <= obuf_d;
            b0_q             <= b0_d;
            b1_q             <= b1_d;
            cnt_q            <= cnt_d;
            out_word_q       <= b0_d;
            out_valid_q      <= out_valid_d;
            resp_ready_q     <= resp_ready_d;
            irq_q            <= irq_d;
            illegal_cmd_q    <= illegal_d;
            bus_doe_q        <= doe_d;
            bus_dout_q       <= dout_d;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    obf_load_a: assert property (resp_acc |=> obf_q && obuf_q == $past(resp_word.val)
        && cd_q == $past(resp_word.cd))
        else $error("output load did not set out-full with the answer");

    obf_clear_a: assert property (rd_done && !rd_a0_q && obf_q && !resp_acc |=> !obf_q)
        else $error("data port read left out-full set");

    ibf_data_a: assert property (wr_done && !ibf_q && !wr_a0_q |=> ibf_q && !in_cd_q
        && ibuf_q == $past(wr_data_q))
        else $error("data write not held as data");

    ibf_take_a: assert property (push |=> !ibf_q && out_valid_q)
        else $error("taken byte did not clear in-full or reach the stream");

    busy_cmd_a: assert property (wr_done && wr_a0_q && !ibf_q && !busy_lock_flag_q
        && !cmd_rsv |=> busy_lock_flag_q && ibf_q && in_cd_q)
        else $error("accepted command did not set busy");

    busy_hold_a: assert property (busy_lock_flag_q && !ctl_done |=> busy_lock_flag_q)
        else $error("busy dropped before completion");

    rsv_cmd_a: assert property (wr_done && wr_a0_q && !ibf_q && !busy_lock_flag_q
        && cmd_rsv |=> illegal_cmd_q && !ibf_q && !busy_lock_flag_q)
        else $error("reserved command was executed");

    no_unsolicit_a: assert property (resp_ready_q |-> busy_lock_flag_q && !obf_q)
        else $error("output buffer open without a command");

    irq_cause_a: assert property (irq_q |-> $past(ctl_done) && $past(cur_irq_q))
        else $error("interrupt without a requesting device command");

    stat_read_a: assert property (rd_act && pin_s2_q[0] |=> bus_doe_q
        && bus_dout_q[hbb_pkg::ST_BUSY_BIT] == $past(busy_lock_flag_q))
        else $error("status read did not show busy");

endmodule : hbb_host_byte_buffer

// >>> rtl/hbb_pkg.sv
// shared constants and types of the host byte buffer port
package hbb_pkg;

    // ------------------------------------------------------------------
    // port map: the low address bit selects the port
    // ------------------------------------------------------------------
    localparam logic [7:0] HOST_DATA_BYTE_ADDR        = 8'hf8;
    localparam logic [7:0] COMMAND_IN_STATUS_OUT_ADDR = 8'hf9;

    // ------------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------------
    localparam int ST_OUT_FULL_BIT = 0;
    localparam int ST_IN_FULL_BIT  = 1;
    localparam int ST_BUSY_BIT     = 2;
    localparam int ST_CD_BIT       = 3;

    // ------------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------------
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CODE_W   = 5;
    localparam int CMD_CTL_LSB  = 5;
    localparam int CMD_CTL_W    = 2;
    localparam int CMD_IRQ_BIT  = 7;
    localparam int CMD_DEV_BIT  = 4;

    localparam logic [4:0] RSV_A_LO = 5'h0b;
    localparam logic [4:0] RSV_A_HI = 5'h0f;
    localparam logic [4:0] RSV_B_LO = 5'h1a;
    localparam logic [4:0] RSV_B_HI = 5'h1f;

    // ------------------------------------------------------------------
    // reset values and buffer depth
    // ------------------------------------------------------------------
    localparam logic       FLAG_RST  = 1'b0;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef struct packed {
        logic       cd;
        logic [7:0] val;
    } hbb_word_t;

    function automatic logic hbb_is_reserved(input logic [4:0] code);
        return ((code >= RSV_A_LO) && (code <= RSV_A_HI)) ||
               ((code >= RSV_B_LO) && (code <= RSV_B_HI));
    endfunction : hbb_is_reserved

endpackage : hbb_pkg

// >>> test/hbb_ctrl_model.sv
// controller model: takes stream words, answers commands, reports completion
module hbb_ctrl_model
(
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire hbb_pkg::hbb_word_t out_word,
    input  wire logic               out_valid,
    output logic                    out_ready,
    output hbb_pkg::hbb_word_t      resp_word,
    output logic                    resp_valid,
    input  wire logic               resp_ready,
    output logic                    ctl_done,
    input  wire logic               stall,
    input  wire logic [7:0]         ans_val
);
    timeunit 1ns;
    timeprecision 1ns;
    hbb_pkg::hbb_word_t q[$];
    hbb_pkg::hbb_word_t w;
    int                 n;

    assign out_ready = !stall;

    always @(posedge mclk)
        if (rst_n && out_valid && out_ready)
            q.push_back(out_word);

    // hold the answer until the buffer takes it, then let the lines wander
    task automatic answer(input logic cd, input logic [7:0] v);
        @(negedge mclk);
        resp_word = hbb_pkg::hbb_word_t'({cd, v});
        resp_valid = 1'b1;
        n = 0;
        @(posedge mclk);
        while (!resp_ready && n < 500)
        begin
            n++;
            @(posedge mclk);
        end
        @(negedge mclk);
        resp_valid = 1'b0;
        resp_word = hbb_pkg::hbb_word_t'({!cd, ~v});
    endtask : answer

    initial
    begin
        resp_valid = 1'b0;
        resp_word = '0;
        ctl_done = 1'b0;
        forever
        begin
            @(negedge mclk);
            if (q.size() != 0)
            begin
                w = q.pop_front();
                // data without a command gets no answer
                if (w.cd)
                begin
                    case (w.val[4:0])
                        5'h10: answer(1'b0, ans_val);
                        5'h11: answer(1'b1, ans_val);
                        5'h12:
                        begin
                            n = 0;
                            while (q.size() == 0 && n < 2000)
                            begin
                                @(negedge mclk);
                                n++;
                            end
                            if (q.size() != 0)
                                void'(q.pop_front());
                        end
                        default: ;
                    endcase
                    @(negedge mclk);
                    ctl_done = 1'b1;
                    @(negedge mclk);
                    ctl_done = 1'b0;
                end
            end
        end
    end
endmodule : hbb_ctrl_model

// >>> test/hbb_host_byte_buffer_tb.sv
// self-checking bench of the host byte buffer port
module hbb_host_byte_buffer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 20000;
    logic               mclk, rst_n, bus_a0, bus_cs_n, bus_rd_n, bus_wr_n, stall;
    logic [7:0]         bus_din, bus_dout_q, ans_val, rb;
    logic               bus_doe_q, out_valid_q, out_ready, resp_valid, resp_ready_q;
    logic               ctl_done, busy_lock_flag_q, irq_q, illegal_cmd_q;
    hbb_pkg::hbb_word_t out_word_q, resp_word;
    hbb_pkg::hbb_word_t exp_q[$];
    logic [15:0]        rnd;
    int                 bad_count = 0, checks = 0, cyc = 0, irq_cnt = 0, ill_cnt = 0, k;

    hbb_host_byte_buffer i_dut (.mclk(mclk), .rst_n(rst_n), .bus_din(bus_din),
        .bus_a0(bus_a0), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_dout_q(bus_dout_q), .bus_doe_q(bus_doe_q), .out_word_q(out_word_q),
        .out_valid_q(out_valid_q), .out_ready(out_ready), .resp_word(resp_word),
        .resp_valid(resp_valid), .resp_ready_q(resp_ready_q), .ctl_done(ctl_done),
        .busy_lock_flag_q(busy_lock_flag_q), .irq_q(irq_q), .illegal_cmd_q(illegal_cmd_q));

    hbb_ctrl_model i_ctrl (.mclk(mclk), .rst_n(rst_n), .out_word(out_word_q),
        .out_valid(out_valid_q), .out_ready(out_ready), .resp_word(resp_word),
        .resp_valid(resp_valid), .resp_ready(resp_ready_q), .ctl_done(ctl_done),
        .stall(stall), .ans_val(ans_val));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask : check_byte

    task automatic check_word(input hbb_pkg::hbb_word_t e, input hbb_pkg::hbb_word_t s);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] stream word expected %h seen %h", e, s);
        end
    endtask : check_word

    task automatic bus_wr(input logic a0, input logic [7:0] d);
        @(negedge mclk);
        bus_a0 = a0;
        bus_din = d;
        bus_cs_n = 1'b0;
        bus_wr_n = 1'b0;
        repeat (4) @(negedge mclk);
        bus_cs_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_din = ~d;
        repeat (5) @(negedge mclk);
    endtask : bus_wr

    task automatic bus_rd(input logic a0, output logic [7:0] d);
        @(negedge mclk);
        bus_a0 = a0;
        bus_cs_n = 1'b0;
        bus_rd_n = 1'b0;
        repeat (5) @(negedge mclk);
        check_byte("drive enable", 8'h01, {7'h00, bus_doe_q});
        d = bus_dout_q;
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        repeat (5) @(negedge mclk);
        check_byte("drive release", 8'h00, {7'h00, bus_doe_q});
    endtask : bus_rd

    task automatic status(input logic [7:0] e);
        bus_rd(1'b1, rb);
        check_byte("status byte", e, rb);
        check_byte("busy flag", {7'h00, e[2]}, {7'h00, busy_lock_flag_q});
    endtask : status

    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        k = 0;
        bus_rd(1'b1, rb);
        while ((rb & m) != v && k < 100)
        begin
            k++;
            bus_rd(1'b1, rb);
        end
        check_byte("polled status", v, rb & m);
    endtask : poll

    task automatic cmd(input logic [7:0] c);
        poll(8'h04, 8'h00);
        exp_q.push_back(hbb_pkg::hbb_word_t'({1'b1, c}));
        bus_wr(1'b1, c);
    endtask : cmd

    always @(posedge mclk)
    begin
        cyc++;
        if (irq_q === 1'b1)
            irq_cnt++;
        if (illegal_cmd_q === 1'b1)
            ill_cnt++;
        if (rst_n && out_valid_q && out_ready)
        begin
            if (exp_q.size() == 0)
            begin
                checks++;
                bad_count++;
                $display("[ERR] stream word expected none seen %h", out_word_q);
            end
            else
                check_word(exp_q.pop_front(), out_word_q);
        end
        if (cyc == LIMIT)
        begin
            bad_count++;
            finish_test();
        end
    end

    initial
    begin
        {bus_din, bus_a0, bus_cs_n, bus_rd_n, bus_wr_n} = 12'h007;
        {stall, ans_val, rst_n} = 10'h000;
        rnd = 16'h7970;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        check_byte("enable at reset", 8'h00, {7'h00, bus_doe_q});
        status(8'h00);
        // ---------------------------------------------------------------
        // read commands: data answer, status answer, system command
        // ---------------------------------------------------------------
        rnd = lfsr(rnd);
        ans_val = rnd[7:0];
        cmd({1'b0, rnd[9:8], 5'h10});
        poll(8'h05, 8'h01);
        status(8'h01);
        bus_rd(1'b0, rb);
        check_byte("data port", ans_val, rb);
        status(8'h00);
        cmd(8'h91);
        poll(8'h05, 8'h01);
        status(8'h09);
        bus_rd(1'b0, rb);
        check_byte("status answer", ans_val, rb);
        cmd(8'h82);
        poll(8'h04, 8'h00);
        check_byte("interrupt count", 8'h01, 8'(irq_cnt));
        // ---------------------------------------------------------------
        // write command, refused command, reserved codes
        // ---------------------------------------------------------------
        cmd(8'h12);
        status(8'h0c);
        bus_wr(1'b1, 8'h02);
        rnd = lfsr(rnd);
        exp_q.push_back(hbb_pkg::hbb_word_t'({1'b0, rnd[7:0]}));
        bus_wr(1'b0, rnd[7:0]);
        poll(8'h06, 8'h00);
        status(8'h00);
        for (k = 0; k < 32; k++)
            if ((k >= 11 && k <= 15) || k >= 26)
            begin
                rnd = lfsr(rnd);
                bus_wr(1'b1, {rnd[7:5], 5'(k)});
            end
        check_byte("illegal count", 8'h0b, 8'(ill_cnt));
        // ---------------------------------------------------------------
        // stalled controller: two entries, one held, one refused
        // ---------------------------------------------------------------
        stall = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            if (i < 3)
                exp_q.push_back(hbb_pkg::hbb_word_t'({1'b0, rnd[7:0]}));
            bus_wr(1'b0, rnd[7:0]);
        end
        status(8'h02);
        stall = 1'b0;
        poll(8'h02, 8'h00);
        k = 0;
        while (exp_q.size() != 0 && k < 100)
        begin
            @(negedge mclk);
            k++;
        end
        check_byte("pending words", 8'h00, 8'(exp_q.size()));
        // reset in mid-command: busy and the buffer flags must drop
        cmd(8'h12);
        status(8'h0c);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        status(8'h00);
        finish_test();
    end
endmodule : hbb_host_byte_buffer_tb
